// ===== rtl/sla_adaptor.sv
`timescale 1ns/100ps
module sla_adaptor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_select_low_i,
  input wire logic reg_select_high_i,
  input wire logic host_read_write_n_i,
  input wire logic host_select_n_i,
  input wire logic [7:0] host_byte_bus_i,
  output logic [7:0] host_byte_bus_o,
  output logic host_byte_bus_oe_o,
  input wire logic serial_rx_line_i,
  output logic serial_tx_line_o,
  input wire logic bit_rate_strap_i,
  output logic tx_ready_irq_o,
  output logic rx_data_irq_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [sla_pkg::SYNC_W-1:0] pin_meta;
  logic [sla_pkg::SYNC_W-1:0] pin_sync;
  wire [sla_pkg::SYNC_W-1:0] pin_raw = {
    bit_rate_strap_i,
    serial_rx_line_i,
    host_byte_bus_i,
    host_select_n_i,
    host_read_write_n_i,
    reg_select_high_i,
    reg_select_low_i
  };

  // pins and the host are on other clocks; only pin_sync is read below
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= {sla_pkg::SYNC_W{1'h0}};
      pin_sync <= {sla_pkg::SYNC_W{1'h0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire [1:0] sel = pin_sync[1:0];
  wire rd_wr_n = pin_sync[2];
  wire cs_n = pin_sync[3];
  wire [7:0] wr_byte = pin_sync[11:4];
  wire rx_line = pin_sync[12];
  wire strap = pin_sync[13];

  // ----------------------------------------------------------------
  // bit rate strap
  // ----------------------------------------------------------------
  // caught once after reset so the rate never moves under a frame;
  // taken only once the synchronisers hold the pin, not their reset zeros
  logic strap_taken;
  logic [1:0] strap_age;
  logic rate_high;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_taken <= 1'h0;
      strap_age <= 2'h0;
      rate_high <= 1'h0;
    end else if (!strap_taken) begin
      strap_age <= {strap_age[0], 1'h1};
      if (strap_age[1]) begin
        strap_taken <= 1'h1;
        rate_high <= strap;
      end
    end
  end

  wire [2:0] cyc_per_bit = rate_high ? sla_pkg::CYC_PER_BIT_HIGH
                                     : sla_pkg::CYC_PER_BIT_LOW;

  // ----------------------------------------------------------------
  // host cycle decode
  // ----------------------------------------------------------------
  logic cs_n_prev;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_n_prev <= 1'h1;
    end else begin
      cs_n_prev <= cs_n;
    end
  end

  // one access per chip select fall; data and direction are already
  // settled by then since the host sets them up first
  wire cycle_start = cs_n_prev && !cs_n;
  wire rd_start = cycle_start && rd_wr_n;
  wire wr_start = cycle_start && !rd_wr_n;

  wire rd_rx_byte = rd_start && (sel == sla_pkg::SEL_RX_BYTE);
  wire wr_tx_byte = wr_start && (sel == sla_pkg::SEL_TX_BYTE);
  wire wr_rx_stat = wr_start && (sel == sla_pkg::SEL_RX_STAT);
  wire wr_tx_stat = wr_start && (sel == sla_pkg::SEL_TX_STAT);
  // a write with select 0,0 matches nothing above and is dropped

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] link_receive_byte;
  logic [7:0] link_transmit_byte;
  logic data_present;
  logic rx_irq_en;
  logic tx_ready;
  logic tx_irq_en;
  logic tx_pend;
  logic ack_wait;
  logic ack_pend;

  wire rx_byte_valid;
  wire [7:0] rx_byte;
  wire rx_ack_seen;
  wire tx_busy;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_receive_byte <= sla_pkg::BYTE_ZERO;
      link_transmit_byte <= sla_pkg::BYTE_ZERO;
    end else begin
      if (rx_byte_valid) begin
        link_receive_byte <= rx_byte;
      end
      if (wr_tx_byte) begin
        link_transmit_byte <= wr_byte;
      end
    end
  end

  // status/control writes only touch the enable bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_irq_en <= 1'h0;
      tx_irq_en <= 1'h0;
    end else begin
      if (wr_rx_stat) begin
        rx_irq_en <= wr_byte[sla_pkg::STAT_IE_BIT];
      end
      if (wr_tx_stat) begin
        tx_irq_en <= wr_byte[sla_pkg::STAT_IE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  // a new byte arriving in the clearing cycle keeps the flag set
  wire next_data_present = rx_byte_valid | (data_present & ~rd_rx_byte);
  // an acknowledge in the same cycle as a host write keeps ready set
  wire next_tx_ready = rx_ack_seen | (tx_ready & ~wr_tx_byte);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_present <= 1'h0;
      tx_ready <= 1'h1;
    end else begin
      data_present <= next_data_present;
      tx_ready <= next_tx_ready;
    end
  end

  // ----------------------------------------------------------------
  // transmit scheduling
  // ----------------------------------------------------------------
  // acknowledges go first so the far sender is never held up by us;
  // a byte goes out only once the previous one has been acknowledged
  wire launch_ack = ack_pend && !tx_busy;
  wire launch_data = tx_pend && !ack_wait && !tx_busy && !ack_pend;
  wire tx_start = launch_ack || launch_data;

  wire next_ack_pend = rd_rx_byte | (ack_pend & ~launch_ack);
  wire next_tx_pend = wr_tx_byte | (tx_pend & ~launch_data);
  wire next_ack_wait = launch_data | (ack_wait & ~rx_ack_seen);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_pend <= 1'h0;
      tx_pend <= 1'h0;
      ack_wait <= 1'h0;
    end else begin
      ack_pend <= next_ack_pend;
      tx_pend <= next_tx_pend;
      ack_wait <= next_ack_wait;
    end
  end

  // ----------------------------------------------------------------
  // link ends
  // ----------------------------------------------------------------
  // one wire each way carries both packets and acknowledges
  sla_link_tx u_tx (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cyc_per_bit_i(cyc_per_bit),
    .start_i(tx_start),
    .ack_i(launch_ack),
    .byte_i(link_transmit_byte),
    .busy_o(tx_busy),
    .line_o(serial_tx_line_o)
  );

  sla_link_rx u_rx (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cyc_per_bit_i(cyc_per_bit),
    .line_i(rx_line),
    .ack_o(rx_ack_seen),
    .byte_valid_o(rx_byte_valid),
    .byte_o(rx_byte)
  );

  // ----------------------------------------------------------------
  // host read path
  // ----------------------------------------------------------------
  wire [7:0] rx_stat = {6'h00, rx_irq_en, data_present};
  wire [7:0] tx_stat = {6'h00, tx_irq_en, tx_ready};

  // the transmit byte is write only and reads back as zero
  wire [7:0] next_rd_byte =
    (sel == sla_pkg::SEL_RX_BYTE) ? link_receive_byte :
    (sel == sla_pkg::SEL_RX_STAT) ? rx_stat :
    (sel == sla_pkg::SEL_TX_STAT) ? tx_stat :
    sla_pkg::BYTE_ZERO;

  wire next_bus_oe = !cs_n && rd_wr_n;

  // the bus tracks the register live while selected, whatever the link does
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_byte_bus_o <= sla_pkg::BYTE_ZERO;
      host_byte_bus_oe_o <= 1'h0;
    end else begin
      host_byte_bus_o <= next_rd_byte;
      host_byte_bus_oe_o <= next_bus_oe;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_ready_irq_o <= 1'h0;
      rx_data_irq_o <= 1'h0;
    end else begin
      tx_ready_irq_o <= next_tx_ready & tx_irq_en;
      rx_data_irq_o <= next_data_present & rx_irq_en;
    end
  end
endmodule // sla_adaptor

// ===== rtl/sla_pkg.sv
package sla_pkg;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int BIT_RATE_LOW_BPS = 10_000_000;
  localparam int BIT_RATE_HIGH_BPS = 20_000_000;
  localparam logic [2:0] CYC_PER_BIT_LOW = 3'(SYS_CLK_HZ / BIT_RATE_LOW_BPS);
  localparam logic [2:0] CYC_PER_BIT_HIGH = 3'(SYS_CLK_HZ / BIT_RATE_HIGH_BPS);
  localparam int BYTE_W = 8;
  localparam logic [3:0] DATA_FRAME_BITS = 4'hB;
  localparam logic [3:0] ACK_FRAME_BITS = 4'h2;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [1:0] SEL_RX_BYTE = 2'h0;
  localparam logic [1:0] SEL_TX_BYTE = 2'h1;
  localparam logic [1:0] SEL_RX_STAT = 2'h2;
  localparam logic [1:0] SEL_TX_STAT = 2'h3;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_IE_BIT = 1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int SYNC_W = 14;
endpackage

// ===== rtl/sla_link_tx.sv
`timescale 1ns/100ps
module sla_link_tx (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] cyc_per_bit_i,
  input wire logic start_i,
  input wire logic ack_i,
  input wire logic [7:0] byte_i,
  output logic busy_o,
  output logic line_o
);
  logic [10:0] shreg;
  logic [3:0] bits_left;
  logic [2:0] cnt;
  wire [10:0] frame = ack_i ? {9'h000, 2'h1} : {1'h0, byte_i, 2'h3};
  wire [3:0] frame_len = ack_i ? sla_pkg::ACK_FRAME_BITS : sla_pkg::DATA_FRAME_BITS;
  wire bit_end = (cnt == 3'h0);

  assign busy_o = (bits_left != 4'h0);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg <= 11'h000;
      bits_left <= 4'h0;
      cnt <= 3'h0;
      line_o <= 1'h0;
    end else if (start_i && !busy_o) begin
      shreg <= frame;
      bits_left <= frame_len;
      cnt <= cyc_per_bit_i - 3'h1;
      line_o <= frame[0];
    end else if (busy_o && bit_end) begin
      shreg <= {1'h0, shreg[10:1]};
      bits_left <= bits_left - 4'h1;
      cnt <= cyc_per_bit_i - 3'h1;
      line_o <= (bits_left > 4'h1) ? shreg[1] : 1'h0;
    end else if (busy_o) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule // sla_link_tx

// ===== rtl/sla_link_rx.sv
`timescale 1ns/100ps
module sla_link_rx (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] cyc_per_bit_i,
  input wire logic line_i,
  output logic ack_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  typedef enum logic [1:0] {RX_IDLE, RX_KIND, RX_DATA, RX_STOP} sla_rx_state_t;
  sla_rx_state_t state;
  logic [2:0] cnt;
  logic [2:0] bitno;
  wire [2:0] half = {1'h0, cyc_per_bit_i[2:1]};
  wire center = (cnt == 3'h0);
  wire [2:0] reload = cyc_per_bit_i - 3'h1;

  // first edge seen: aim at the middle of the second bit, then one bit apart
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= RX_IDLE;
      cnt <= 3'h0;
      bitno <= 3'h0;
      ack_o <= 1'h0;
      byte_valid_o <= 1'h0;
      byte_o <= sla_pkg::BYTE_ZERO;
    end else begin
      ack_o <= 1'h0;
      byte_valid_o <= 1'h0;
      if (state != RX_IDLE) begin
        cnt <= center ? reload : cnt - 3'h1;
      end
      case (state)
        RX_IDLE: begin
          if (line_i) begin
            state <= RX_KIND;
            cnt <= cyc_per_bit_i + half - 3'h1;
          end
        end
        RX_KIND: begin
          if (center) begin
            bitno <= 3'h0;
            if (line_i) begin
              state <= RX_DATA;
            end else begin
              ack_o <= 1'h1;
              state <= RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (center) begin
            byte_o <= {line_i, byte_o[7:1]};
            bitno <= bitno + 3'h1;
            if (bitno == sla_pkg::LAST_DATA_BIT) begin
              state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (center) begin
            byte_valid_o <= 1'h1;
            state <= RX_IDLE;
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end
endmodule // sla_link_rx

// ===== dv/sla_adaptor_sva.sv
`timescale 1ns/100ps
module sla_adaptor_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_select_low_i,
  input wire logic reg_select_high_i,
  input wire logic host_read_write_n_i,
  input wire logic host_select_n_i,
  input wire logic [7:0] host_byte_bus_i,
  input wire logic [7:0] host_byte_bus_o,
  input wire logic host_byte_bus_oe_o,
  input wire logic serial_rx_line_i,
  input wire logic serial_tx_line_o,
  input wire logic bit_rate_strap_i,
  input wire logic tx_ready_irq_o,
  input wire logic rx_data_irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [1:0] sel = {reg_select_high_i, reg_select_low_i};
  wire rd_on = !host_select_n_i && host_read_write_n_i;
  wire wr_on = !host_select_n_i && !host_read_write_n_i;
  // ----------------
  // access shapes
  // ----------------
  // four samples cover the two sync flops plus the take edge
  sequence s_acc(logic w, logic [1:0] s);
    (w && sel == s)[*4];
  endsequence
  sequence s_rx_take;
    rx_data_irq_o && rd_on && sel == 2'h0 ##1 s_acc(rd_on, 2'h0);
  endsequence
  property p_rst_line; $rose(rst_n_i) |-> !serial_tx_line_o; endproperty
  property p_rst_irq; $rose(rst_n_i) |-> (!tx_ready_irq_o && !rx_data_irq_o)[*2]; endproperty
  property p_tx_wr_clr; s_acc(wr_on, 2'h1) |-> ##[0:3] !tx_ready_irq_o; endproperty
  property p_rx_rd_clr; s_rx_take |-> ##[0:3] !rx_data_irq_o; endproperty
  property p_rx_rd_ack; s_rx_take |-> ##[0:60] serial_tx_line_o; endproperty
  // a data frame leads with 8 high clocks at the low rate and 4 at the high rate; this bench only has acks go out at the low rate
  property p_frame_lead; $rose(serial_tx_line_o) |-> serial_tx_line_o[*4]; endproperty
  property p_rd_drive; rd_on[*4] |-> host_byte_bus_oe_o; endproperty
  property p_wr_quiet; wr_on[*4] |-> !host_byte_bus_oe_o; endproperty
  property p_stat_pad;
    host_byte_bus_oe_o && rd_on && sel[1] |-> host_byte_bus_o[7:2] == 6'h00;
  endproperty
  property p_undef_zero;
    host_byte_bus_oe_o && rd_on && sel == 2'h1 |-> host_byte_bus_o == 8'h00;
  endproperty
  a_rst_line: assert property (p_rst_line) else $error("tx line high after reset");
  a_rst_irq: assert property (p_rst_irq) else $error("irq high after reset");
  a_tx_wr_clr: assert property (p_tx_wr_clr) else $error("tx irq kept after write");
  a_rx_rd_clr: assert property (p_rx_rd_clr) else $error("rx irq kept after read");
  a_rx_rd_ack: assert property (p_rx_rd_ack) else $error("no ack after read");
  a_frame_lead: assert property (p_frame_lead) else $error("short lead bit");
  a_rd_drive: assert property (p_rd_drive) else $error("bus not driven on read");
  a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven on write");
  a_stat_pad: assert property (p_stat_pad) else $error("status pad bits set");
  a_undef_zero: assert property (p_undef_zero) else $error("tx byte read not zero");
endmodule // sla_adaptor_sva

bind sla_adaptor sla_adaptor_sva u_sva (.sys_clk_i, .rst_n_i, .reg_select_low_i,
  .reg_select_high_i, .host_read_write_n_i, .host_select_n_i, .host_byte_bus_i,
  .host_byte_bus_o, .host_byte_bus_oe_o, .serial_rx_line_i, .serial_tx_line_o,
  .bit_rate_strap_i, .tx_ready_irq_o, .rx_data_irq_o);

// ===== dv/sla_link_peer.sv
`timescale 1ns/100ps
module sla_link_peer (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int n_ack = 0;
  int ack_dly = 100;
  // clocks per bit: 4 at the low rate, 2 at the high rate
  int bclk = 4;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  bit busy = 0;
  bit tx_wait = 0;
  initial line_o = 1'b0;
  // one wire carries both our bytes and our acks, so frames are serialised
  task automatic send(input logic [10:0] bits, input int n);
    wait (!busy);
    busy = 1;
    #1;
    for (int i = 0; i < n; i++) begin
      line_o = bits[i];
      repeat (bclk) @(posedge clk_i);
      #1;
    end
    line_o = 1'b0;
    busy = 0;
  endtask
  task automatic send_byte(input logic [7:0] d);
    wait (!tx_wait);
    tx_wait = 1;
    send({1'b0, d, 2'b11}, 11);
  endtask
  initial forever begin
    @(posedge line_i);
    repeat (bclk + bclk / 2) @(posedge clk_i);
    if (!line_i) begin
      n_ack++;
      tx_wait = 0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        repeat (bclk) @(posedge clk_i);
        b[i] = line_i;
      end
      repeat (bclk) @(posedge clk_i);
      rx_q.push_back(b);
      // slow acker: the device must hold its next byte meanwhile
      fork
        begin
          repeat (ack_dly) @(posedge clk_i);
          send(11'h001, 2);
        end
      join_none
    end
  end
endmodule // sla_link_peer

// ===== dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_select_low_i = 1'b0;
  logic reg_select_high_i = 1'b0;
  logic host_read_write_n_i = 1'b1;
  logic host_select_n_i = 1'b1;
  logic [7:0] host_byte_bus_i = 8'h00;
  logic [7:0] host_byte_bus_o;
  logic host_byte_bus_oe_o;
  logic serial_rx_line_i;
  logic serial_tx_line_o;
  logic bit_rate_strap_i = 1'b0;
  logic tx_ready_irq_o;
  logic rx_data_irq_o;
  logic [7:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  int k;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sla_adaptor u_dut (.sys_clk_i, .rst_n_i, .reg_select_low_i, .reg_select_high_i,
    .host_read_write_n_i, .host_select_n_i, .host_byte_bus_i, .host_byte_bus_o,
    .host_byte_bus_oe_o, .serial_rx_line_i, .serial_tx_line_o, .bit_rate_strap_i,
    .tx_ready_irq_o, .rx_data_irq_o);
  sla_link_peer u_peer (.clk_i(sys_clk_i), .line_i(serial_tx_line_o),
    .line_o(serial_rx_line_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ----------------
  // host cycles
  // ----------------
  // select, direction and data settle a full clock before chip select falls
  task automatic acc(input logic r, input logic [1:0] s, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    {reg_select_high_i, reg_select_low_i} = s;
    host_read_write_n_i = r;
    host_byte_bus_i = d;
    @(posedge sys_clk_i);
    #1;
    host_select_n_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1;
    rd = host_byte_bus_o;
    host_select_n_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [1:0] s, input logic [7:0] exp);
    acc(1'b1, s, 8'h00);
    chk(rd, exp);
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge sys_clk_i);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk({6'h00, rx_data_irq_o, tx_ready_irq_o}, 8'h00);
    rdc(2'h2, 8'h00);
    rdc(2'h3, 8'h01);
    acc(1'b0, 2'h3, 8'h02);
    chk({7'h00, tx_ready_irq_o}, 8'h01);
    acc(1'b0, 2'h2, 8'h03);
    rdc(2'h2, 8'h02);
    acc(1'b0, 2'h1, 8'hA5);
    rdc(2'h3, 8'h02);
    acc(1'b0, 2'h1, 8'h3C);
    for (int i = 0; i < 1500 && u_peer.rx_q.size() < 2; i++) @(posedge sys_clk_i);
    for (int i = 0; i < 400 && tx_ready_irq_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk(u_peer.rx_q[0], 8'hA5);
    chk(u_peer.rx_q[1], 8'h3C);
    rdc(2'h3, 8'h03);
    u_peer.send_byte(8'h96);
    for (int i = 0; i < 300 && rx_data_irq_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk({7'h00, rx_data_irq_o}, 8'h01);
    rdc(2'h2, 8'h03);
    k = u_peer.n_ack;
    rdc(2'h0, 8'h96);
    chk({7'h00, rx_data_irq_o}, 8'h00);
    for (int i = 0; i < 100 && u_peer.n_ack == k; i++) @(posedge sys_clk_i);
    chk(8'(u_peer.n_ack - k), 8'h01);
    acc(1'b0, 2'h0, 8'h55);
    rdc(2'h0, 8'h96);
    rdc(2'h1, 8'h00);
    // second reset, strap high: the link runs at 2 clocks per bit
    @(posedge sys_clk_i);
    #1 rst_n_i = 1'b0;
    bit_rate_strap_i = 1'b1;
    u_peer.bclk = 2;
    repeat (8) @(posedge sys_clk_i);
    chk({7'h00, serial_tx_line_o}, 8'h00);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk({6'h00, rx_data_irq_o, tx_ready_irq_o}, 8'h00);
    rdc(2'h3, 8'h01);
    acc(1'b0, 2'h3, 8'h02);
    acc(1'b0, 2'h1, 8'h5A);
    for (int i = 0; i < 600 && u_peer.rx_q.size() < 3; i++) @(posedge sys_clk_i);
    chk(u_peer.rx_q[2], 8'h5A);
    for (int i = 0; i < 400 && tx_ready_irq_o !== 1'b1; i++) @(posedge sys_clk_i);
    rdc(2'h3, 8'h03);
    report_and_stop();
  end
endmodule // tb_top
